/* File: hdl/nabe_alu.sv */
`timescale 1ns/1ps

module nabe_alu
   import nabe_pkg::*;
(
   input wire nabe_alu_e op,
   input wire logic [3:0] a,
   input wire logic [3:0] b,
   input wire logic cin,
   output logic [3:0] result,
   output logic cout
);

   logic [4:0] wide;

   // Five-bit result; bit 4 is carry out or borrow.
   always_comb begin
      wide = 5'h00;
      case (op)
         NABE_ADD: wide = {1'b0, a} + {1'b0, b};
         NABE_ADC: wide = {1'b0, a} + {1'b0, b} + {4'h0, cin};
         NABE_SUB: wide = {1'b0, a} - {1'b0, b};
         NABE_SBC: wide = {1'b0, a} - {1'b0, b} - {4'h0, cin};
         NABE_AND: wide = {1'b0, a & b};
         NABE_OR: wide = {1'b0, a | b};
         NABE_XOR: wide = {1'b0, a ^ b};
         default: wide = 5'h00;
      endcase
   end

   // Split result and carry.
   assign result = wide[3:0];
   assign cout = wide[4];

endmodule : nabe_alu

/* File: hdl/nabe_exec.sv */
`timescale 1ns/1ps
`include "nabe_regs.svh"

// Summary of operation
// - Every instruction takes one machine cycle of four clock periods.
// - Plain sum of RAM plus accumulator or register plus immediate.
// - Sum with carry in, result to accumulator, both flags updated.
// - Sum keeping carry updates only the zero flag.
// - Difference RAM minus accumulator or register minus immediate.
// - Difference with borrow also subtracts the carry flag.
// - Bitwise AND into accumulator, zero flag only.
// - Bitwise OR into accumulator, zero flag only.
// - Bitwise XOR into accumulator, zero flag only.
// - Jump on accumulator bit loads low eleven counter bits when set.
// - Jump on accumulator zero or non-zero.
// - Jump on carry set or clear.
// - Decrement RAM, update flags, skip one instruction on condition.
// - Skip one instruction when selected RAM bit is one.
// - Direct RAM address is page times 10H plus address field.
module nabe_exec
   import nabe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] instr_data,
   input wire logic [2:0] page_sel,
   input wire logic [1:0] code_page_reg,
   input wire logic [3:0] ram_rdata,
   input wire nabe_load_s wr_load,
   output logic [`NABE_PC_W-1:0] pc,
   output logic fetch_strobe,
   output logic [3:0] arith_result_reg,
   output logic zero_flag,
   output logic carry_flag,
   output logic [`NABE_RAM_AW-1:0] ram_addr,
   output nabe_ram_s ram_wr
);

   // ----------------------------------------------------------------------
   // Machine cycle sequencing
   // ----------------------------------------------------------------------
   localparam logic [1:0] PH_LAST = 2'(`NABE_MCYCLE_CLKS - 1);
   localparam logic [1:0] PH_FETCH = 2'h0;
   localparam logic [1:0] PH_ADDR = 2'h1;
   localparam logic [1:0] PH_READ = 2'h2;

   logic [1:0] phase;
   logic [15:0] instr;
   logic [3:0] ram_q;
   logic [3:0] work_reg_n [16];

   wire exec_now = (phase == PH_LAST);
   wire [1:0] next_phase = exec_now ? PH_FETCH : phase + 2'h1;

   // Phase counter wraps every four clocks.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase <= PH_FETCH;
      end else begin
         phase <= next_phase;
      end
   end

   // The fetch strobe marks the clock in which the opcode is sampled.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fetch_strobe <= 1'b1;
      end else begin
         fetch_strobe <= (next_phase == PH_FETCH);
      end
   end

   // Opcode is captured once per machine cycle.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         instr <= 16'h0000;
      end else if (phase == PH_FETCH) begin
         instr <= instr_data;
      end
   end

   // ----------------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------------
   wire [7:0] op_hi = instr[15:8];
   wire imm_form = instr[10];
   wire wback = instr[8];
   wire [1:0] op_class = instr[13:12];
   wire is_arith = (instr[15:14] == 2'b00) && instr[11]
                   && (imm_form || !instr[7]);
   wire is_incdec = (op_hi == `NABE_OP_INCDEC);
   wire is_dskip = (op_hi == `NABE_OP_DSKIP);
   wire is_skb = (op_hi[7:1] == `NABE_OP_SKB);
   wire is_jmp = (instr[15:11] == `NABE_OP_JMP);
   wire is_bj = instr[15] && !instr[11];
   wire [10:0] jump_field = instr[10:0];
   wire [1:0] bit_sel = {instr[8], instr[7]};

   // Direct RAM address from page and address field.
   wire [7:0] direct_addr = {1'b0, page_sel, 4'h0}
                            + {1'b0, instr[6:0]};

   // Arithmetic operation select per opcode class.
   nabe_alu_e alu_op;
   always_comb begin
      alu_op = NABE_ADD;
      if (is_arith) begin
         case ({op_class, instr[9]})
            3'b000: alu_op = NABE_ADC;
            3'b001: alu_op = NABE_SBC;
            3'b010: alu_op = NABE_ADD;
            3'b011: alu_op = NABE_SUB;
            3'b100: alu_op = NABE_ADD;
            3'b101: alu_op = NABE_AND;
            3'b110: alu_op = NABE_XOR;
            3'b111: alu_op = NABE_OR;
            default: alu_op = NABE_ADD;
         endcase
      end else if (is_incdec) begin
         alu_op = instr[7] ? NABE_SUB : NABE_ADD;
      end else if (is_dskip) begin
         alu_op = NABE_SUB;
      end
   end

   // Operands: register and immediate, RAM and accumulator, or RAM and 1 for the decrement and increment groups.
   wire use_imm = is_arith && imm_form;
   wire [3:0] wr_sel = work_reg_n[instr[3:0]];
   wire [3:0] alu_a = use_imm ? wr_sel : ram_q;
   wire [3:0] alu_b = use_imm ? instr[7:4]
                      : (is_arith ? arith_result_reg : 4'h1);
   wire [3:0] alu_res;
   wire alu_cout;

   nabe_alu u_alu (
      .op(alu_op),
      .a(alu_a),
      .b(alu_b),
      .cin(carry_flag),
      .result(alu_res),
      .cout(alu_cout)
   );

   // Which state each instruction updates.
   wire acc_upd = is_arith || is_incdec || is_dskip;
   wire cf_upd = (is_arith && !op_class[1]) || is_incdec
                 || is_dskip;
   wire ram_upd = (is_arith && wback && !imm_form) || is_incdec
                  || is_dskip;
   wire wr_upd = is_arith && wback && imm_form;
   wire res_zero = (alu_res == 4'h0);

   // ----------------------------------------------------------------------
   // Branch and skip
   // ----------------------------------------------------------------------
   logic br_take;
   always_comb begin
      case (instr[14:12])
         `NABE_BR_NZ: br_take = (arith_result_reg != 4'h0);
         `NABE_BR_Z: br_take = (arith_result_reg == 4'h0);
         `NABE_BR_C: br_take = carry_flag;
         `NABE_BR_NC: br_take = !carry_flag;
         default: br_take = arith_result_reg[instr[13:12]];
      endcase
   end

   wire dskip_take = is_dskip && (instr[7] ? !res_zero : res_zero);
   wire skb_take = is_skb && ram_q[bit_sel];
   wire [12:0] pc_seq = pc + 13'h0001;
   wire [12:0] pc_skip = pc + 13'h0002;
   wire [12:0] pc_long = {code_page_reg, jump_field};
   wire [12:0] pc_short = {pc[12:11], jump_field};
   wire [12:0] next_pc = is_jmp ? pc_long
                         : (is_bj && br_take) ? pc_short
                         : (dskip_take || skb_take) ? pc_skip
                         : pc_seq;

   // ----------------------------------------------------------------------
   // State updates
   // ----------------------------------------------------------------------
   // Program counter advances at the end of each machine cycle.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pc <= `NABE_PC_RESET;
      end else if (exec_now) begin
         pc <= next_pc;
      end
   end

   // RAM address is formed after fetch, read data caught one clock later.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ram_addr <= 8'h00;
         ram_q <= `NABE_NIBBLE_RESET;
      end else begin
         if (phase == PH_ADDR) begin
            ram_addr <= direct_addr;
         end
         if (phase == PH_READ) begin
            ram_q <= ram_rdata;
         end
      end
   end

   // Accumulator and flags.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         arith_result_reg <= `NABE_NIBBLE_RESET;
         zero_flag <= 1'b0;
         carry_flag <= 1'b0;
      end else if (exec_now && acc_upd) begin
         arith_result_reg <= alu_res;
         zero_flag <= res_zero;
         if (cf_upd) begin
            carry_flag <= alu_cout;
         end
      end
   end

   // RAM write-back is a one-clock request after the execute clock.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ram_wr <= '0;
      end else begin
         ram_wr.we <= exec_now && ram_upd;
         ram_wr.addr <= ram_addr;
         ram_wr.wdata <= alu_res;
      end
   end

   // Working registers; execute write-back wins over a preload.
   for (genvar i = 0; i < 16; i++) begin : g_wr
      wire exec_hit = exec_now && wr_upd && (instr[3:0] == 4'(i));
      wire load_hit = wr_load.wr_en && (wr_load.wr_idx == 4'(i));
      always_ff @(posedge clock or posedge rst) begin
         if (rst) begin
            work_reg_n[i] <= `NABE_NIBBLE_RESET;
         end else if (exec_hit) begin
            work_reg_n[i] <= alu_res;
         end else if (load_hit) begin
            work_reg_n[i] <= wr_load.wr_data;
         end
      end
   end

endmodule : nabe_exec

/* File: hdl/nabe_pkg.sv */
package nabe_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   // Operation applied by the nibble arithmetic unit.
   typedef enum logic [2:0] {
      NABE_ADD,
      NABE_ADC,
      NABE_SUB,
      NABE_SBC,
      NABE_AND,
      NABE_OR,
      NABE_XOR
   } nabe_alu_e;

   // Preload of one working register.
   typedef struct packed {
      logic wr_en;
      logic [3:0] wr_idx;
      logic [3:0] wr_data;
   } nabe_load_s;

   // Data RAM write request.
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [3:0] wdata;
   } nabe_ram_s;

endpackage : nabe_pkg

/* File: hdl/nabe_regs.svh */
`ifndef NABE_REGS_SVH
`define NABE_REGS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// System clock period and the machine cycle of four oscillator periods.
`define NABE_CLK_NS 50
`define NABE_MCYCLE_NS 200
`define NABE_MCYCLE_CLKS (`NABE_MCYCLE_NS / `NABE_CLK_NS)

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define NABE_PC_W 13
`define NABE_RAM_AW 8
`define NABE_PC_RESET 13'h0000
`define NABE_NIBBLE_RESET 4'h0

// ----------------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------------
// High byte of the increment and decrement group.
`define NABE_OP_INCDEC 8'h4a
// High byte of the decrement and skip group.
`define NABE_OP_DSKIP 8'h48
// Upper seven bits of the skip on RAM bit group.
`define NABE_OP_SKB 7'h54
// Upper five bits of the long jump.
`define NABE_OP_JMP 5'h0e
// Branch condition selectors in bits 14 to 12.
`define NABE_BR_NZ 3'h4
`define NABE_BR_NC 3'h5
`define NABE_BR_Z 3'h6
`define NABE_BR_C 3'h7

`endif

/* File: test/nabe_exec_checker.sv */
`timescale 1ns/1ps
`include "nabe_regs.svh"

// Watches cycle timing, results and RAM write-back at the core's ports.
module nabe_exec_checker
   import nabe_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [15:0] instr_data,
   input wire logic [2:0] page_sel,
   input wire logic [1:0] code_page_reg,
   input wire logic [`NABE_PC_W-1:0] pc,
   input wire logic fetch_strobe,
   input wire logic [3:0] arith_result_reg,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic [`NABE_RAM_AW-1:0] ram_addr,
   input wire nabe_ram_s ram_wr
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // Direct address formed from the page and the opcode field.
   wire logic [7:0] want_addr = 8'({page_sel, 4'h0}) + 8'(instr_data[6:0]);

   AST_CYCLE: assert property (
      fetch_strobe |=> !fetch_strobe [*3] ##1 fetch_strobe)
      else $error("fetch strobe is not one clock in four");
   AST_STATE_AT_FETCH: assert property (
      $changed({pc, arith_result_reg, zero_flag, carry_flag}) |-> fetch_strobe)
      else $error("core state changed outside the fetch clock");
   AST_ZERO_TRACK: assert property (
      $changed(arith_result_reg) |-> zero_flag == (arith_result_reg == 4'h0))
      else $error("zero flag disagrees with the new result");
   AST_WE_AT_FETCH: assert property (
      ram_wr.we |-> fetch_strobe && !$past(ram_wr.we))
      else $error("RAM write is not a one clock pulse in fetch");
   AST_WE_DATA: assert property (
      ram_wr.we |-> ram_wr.wdata == arith_result_reg
      && ram_wr.addr == ram_addr)
      else $error("RAM write differs from result or address");
   AST_RAM_ADDR: assert property (
      fetch_strobe |-> ##2 ram_addr == $past(want_addr, 2))
      else $error("direct RAM address is wrong");
   AST_LONG_JUMP: assert property (
      fetch_strobe && instr_data[15:11] == `NABE_OP_JMP |->
      ##4 pc == {$past(code_page_reg), $past(instr_data[10:0], 4)})
      else $error("long jump target is wrong");
   AST_SKIP_KEEPS: assert property (
      fetch_strobe && instr_data[15:9] == `NABE_OP_SKB |->
      ##4 $stable({arith_result_reg, zero_flag, carry_flag}))
      else $error("bit skip changed result or flags");
endmodule : nabe_exec_checker

/* File: test/nibble_alu_branch_exec_tb.sv */
`timescale 1ns/1ps
`include "nabe_regs.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end

module nibble_alu_branch_exec_tb
   import nabe_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [15:0] instr_data = 16'h0000;
   logic [2:0] page_sel = 3'h0;
   logic [1:0] code_page_reg = 2'h0;
   nabe_load_s wr_load = '0;
   wire logic [3:0] ram_rdata;
   logic [12:0] pc, m_pc;
   logic fetch_strobe, zero_flag, carry_flag, m_zf, m_cf;
   logic [3:0] arith_result_reg, m_acc;
   logic [7:0] ram_addr;
   nabe_ram_s ram_wr;
   logic [3:0] ram [256];
   logic [3:0] mram [256];
   logic [3:0] wr [16];
   logic [18:0] note_q [$];
   logic [18:0] exp_n;
   logic [15:0] op_q [$];
   logic [15:0] op;
   logic [31:0] d;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 32'heaaf3802;

   nabe_exec dut (.clock(clock), .rst(rst), .instr_data(instr_data),
      .page_sel(page_sel), .code_page_reg(code_page_reg),
      .ram_rdata(ram_rdata), .wr_load(wr_load), .pc(pc),
      .fetch_strobe(fetch_strobe), .arith_result_reg(arith_result_reg),
      .zero_flag(zero_flag), .carry_flag(carry_flag),
      .ram_addr(ram_addr), .ram_wr(ram_wr));

   // Data RAM: zero latency read, write on the design's pulse.
   assign ram_rdata = ram[ram_addr];
   always @(posedge clock) if (ram_wr.we) ram[ram_wr.addr] <= ram_wr.wdata;

   initial forever #25 clock = ~clock;

   // Drives one opcode and notes the state expected after it.
   task automatic issue(input logic [15:0] o);
      logic [31:0] r;
      logic [7:0] ad;
      logic [3:0] a, b;
      logic [4:0] s;
      logic [2:0] c;
      logic [12:0] p;
      logic hit;
      r = $random(seed);
      instr_data = o;
      page_sel = r[2:0];
      code_page_reg = r[4:3];
      ad = 8'({page_sel, 4'h0}) + 8'(o[6:0]);
      a = o[10] ? wr[o[3:0]] : mram[ad];
      b = o[10] ? o[7:4] : m_acc;
      c = o[14:12];
      p = m_pc;
      hit = 1'b0;
      m_pc = p + 13'h1;
      if (o[15:14] == 2'b00 && o[11] && !(o[7] && !o[10])) begin
         case ({o[13:12], o[9]})
            3'd0: s = a + b + m_cf;
            3'd1: s = a - b - m_cf;
            3'd2, 3'd4: s = a + b;
            3'd3: s = a - b;
            3'd5: s = a & b;
            3'd6: s = a ^ b;
            default: s = a | b;
         endcase
         m_acc = s[3:0];
         m_zf = s[3:0] == 4'h0;
         if (!o[13]) m_cf = s[4];
         if (o[8] && o[10]) wr[o[3:0]] = s[3:0];
         if (o[8] && !o[10]) mram[ad] = s[3:0];
      end else if (o[15:10] == 6'h12 && !o[8]) begin
         s = (o[7] || !o[9]) ? a - 5'h1 : a + 5'h1;
         m_acc = s[3:0];
         m_zf = s[3:0] == 4'h0;
         m_cf = s[4];
         mram[ad] = s[3:0];
         hit = !o[9] && ((s[3:0] == 4'h0) ^ o[7]);
      end else if (o[15:9] == `NABE_OP_SKB) hit = a[{o[8], o[7]}];
      else if (o[15:11] == `NABE_OP_JMP) m_pc = {code_page_reg, o[10:0]};
      else if (o[15] && !o[11] && (c[2] ? (c[0] ? m_cf == c[1] :
         (m_acc == 4'h0) == c[1]) : m_acc[c[1:0]])) begin
         m_pc = {p[12:11], o[10:0]};
      end
      if (hit) m_pc = p + 13'h2;
      note_q.push_back({m_pc, m_acc, m_zf, m_cf});
   endtask : issue

   // Feeds an opcode at every fetch clock; no-ops when nothing waits.
   // It starts in the falling edge that ends reset, so the first fetch
   // after reset already carries a noted opcode.
   initial begin
      wait (!rst);
      forever begin
         if (fetch_strobe) issue(op_q.size() ? op_q.pop_front() : 16'h0);
         @(negedge clock);
      end
   end

   // Compares the state shown in each fetch clock with the oldest note.
   always @(posedge clock) begin
      #1;
      if (!rst && fetch_strobe && note_q.size()) begin
         exp_n = note_q.pop_front();
         `CHK({pc, arith_result_reg, zero_flag, carry_flag}, exp_n)
      end
   end

   task final_report;
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report

   initial begin
      #200000;
      bad_count++;
      final_report();
   end

   // Preloads registers, then runs random opcodes of every class.
   initial begin
      {m_pc, m_acc, m_zf, m_cf} = '0;
      for (int i = 0; i < 256; i++) begin
         d = $random(seed);
         ram[i] = d[3:0];
         mram[i] = d[3:0];
      end
      for (int i = 0; i < 16; i++) wr[i] = 4'h0;
      repeat (10) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (int i = 0; i < 16; i++) begin
         @(negedge clock);
         d = $random(seed);
         wr[i] = d[3:0];
         wr_load = {1'b1, i[3:0], d[3:0]};
      end
      @(negedge clock);
      wr_load = '0;
      for (int i = 0; i < 400; i++) begin
         d = $random(seed);
         op = d[15:0];
         case (d[18:16])
            3'd0, 3'd1: begin
               op[15:14] = 2'b00;
               op[11] = 1'b1;
               if (!op[10]) op[7] = &d[21:19];
            end
            3'd2: op[15:8] = d[21] ? 8'h4a : 8'h48;
            3'd3: op[15:9] = `NABE_OP_SKB;
            3'd4, 3'd5: {op[15], op[11]} = 2'b10;
            3'd6: op[15:11] = `NABE_OP_JMP;
            default: ;
         endcase
         op_q.push_back(op);
      end
      wait (op_q.size() == 0);
      repeat (8) @(negedge clock);
      for (int i = 0; i < 256; i++) `CHK(ram[i], mram[i])
      final_report();
   end
endmodule : nibble_alu_branch_exec_tb

bind nabe_exec nabe_exec_checker chk (.clock(clock), .rst(rst),
   .instr_data(instr_data), .page_sel(page_sel),
   .code_page_reg(code_page_reg), .pc(pc), .fetch_strobe(fetch_strobe),
   .arith_result_reg(arith_result_reg), .zero_flag(zero_flag),
   .carry_flag(carry_flag), .ram_addr(ram_addr), .ram_wr(ram_wr));
